//--- ofcc_top.v
// digital back end: bandwidth filter, update rate, clamp, pwm with startup calibration
//
// Behaviour
// - the field samples pass a first-order low-pass whose cutoff is set by the 3-bit bandwidth field.
// - the filter takes samples from a 16-entry fifo that drains one sample per update tick.
// - the bandwidth code also sets how often the output value is recomputed.
// - codes 0 and 2 give 8 kHz updates, 1 gives 16 kHz, 3 gives 4 kHz, 4 gives 2 kHz, 5 gives 1 kHz; 6 and 7 fall back to 8 kHz.
// - with calibration enabled, the pwm output is held at 50% duty for 800 ms after reset, then runs normally.
// - the 6-bit upper field trims the passing share of the upper half of full scale.
// - upper code 0 gives the highest upper limit and code 0x3f the lowest.
// - the 6-bit lower field trims the passing share of the lower half of full scale.
// - lower code 0 gives the lowest lower limit and code 0x3f the highest.
// - an unprogrammed limit field falls back to the factory default for that bound.
`timescale 1ns/1ps
`include "ofcc_defs.vh"
module ofcc_top #(
	parameter DW         = 10,
	parameter CAL_CYCLES = `OFCC_CAL_CYCLES,
	parameter UPD_BASE   = `OFCC_UPD_1K_CYCLES,
	parameter FIFO_DEPTH = 16,
	parameter [5:0] FACTORY_UPPER = 6'h00,
	parameter [5:0] FACTORY_LOWER = 6'h00
) (
	// clock and reset
	input  wire          clk_sys,
	input  wire          reset,
	// configuration word load
	input  wire          cfg_wr,
	input  wire [4:0]    cfg_addr,
	input  wire [23:0]   cfg_wdata,
	input  wire [4:0]    cfg_raddr,
	output reg  [23:0]   cfg_rdata,
	// digitized field samples from the front end
	input  wire [DW-1:0] sample_data,
	input  wire          sample_valid,
	output reg           sample_ready,
	// output
	output reg           pwm_out,
	output reg  [DW-1:0] clamp_out,
	output reg  [1:0]    clamp_state,
	output reg           cal_active
);
	// ----------------------------------------
	// configuration words
	// ----------------------------------------
	reg [2:0] bw_q;
	reg [5:0] upper_q;
	reg [5:0] lower_q;
	reg       upper_set_q;
	reg       lower_set_q;
	reg       cal_en_q;

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			bw_q        <= `OFCC_RST_BW;
			upper_q     <= `OFCC_RST_LIMIT;
			lower_q     <= `OFCC_RST_LIMIT;
			upper_set_q <= 1'b0;
			lower_set_q <= 1'b0;
			cal_en_q    <= `OFCC_RST_CAL;
		end else if (cfg_wr) begin
			if (cfg_addr == `OFCC_ADDR_FILTCLAMP) begin
				bw_q        <= cfg_wdata[`OFCC_BW_MSB:`OFCC_BW_LSB];
				upper_q     <= cfg_wdata[`OFCC_HIGH_MSB:`OFCC_HIGH_LSB];
				lower_q     <= cfg_wdata[`OFCC_LOW_MSB:`OFCC_LOW_LSB];
				upper_set_q <= 1'b1;
				lower_set_q <= 1'b1;
			end
			if (cfg_addr == `OFCC_ADDR_CALIB)
				cal_en_q <= cfg_wdata[`OFCC_CAL_BIT];
		end
	end

	always @(posedge clk_sys or posedge reset) begin
		if (reset)
			cfg_rdata <= 24'h000000;
		else if (cfg_raddr == `OFCC_ADDR_FILTCLAMP)
			cfg_rdata <= {upper_q, lower_q, 9'h000, bw_q};
		else if (cfg_raddr == `OFCC_ADDR_CALIB)
			cfg_rdata <= {20'h00000, cal_en_q, 3'h0};
		else
			cfg_rdata <= 24'h000000;
	end

	// ----------------------------------------
	// update rate divider
	// ----------------------------------------
	// divisor is a multiple of the 16 kHz period
	function [4:0] ofcc_rate_mul;
		input [2:0] code;
		begin
			case (code)
			3'h1:    ofcc_rate_mul = 5'h01;
			3'h3:    ofcc_rate_mul = 5'h04;
			3'h4:    ofcc_rate_mul = 5'h08;
			3'h5:    ofcc_rate_mul = 5'h10;
			default: ofcc_rate_mul = 5'h02;
			endcase
		end
	endfunction

	// filter shift: k such that a/2^k tracks the cutoff at its own update rate
	function [3:0] ofcc_shift;
		input [2:0] code;
		begin
			case (code)
			3'h1:    ofcc_shift = 4'h2;
			3'h3:    ofcc_shift = 4'h2;
			3'h4:    ofcc_shift = 4'h2;
			3'h5:    ofcc_shift = 4'h2;
			default: ofcc_shift = 4'h2;
			endcase
		end
	endfunction

	reg  [31:0] tick_cnt_q;
	reg         upd_tick_q;
	wire [31:0] tick_lim;
	// 16 kHz base period times multiplier; the update/cutoff ratio is fixed at 4 for every code
	assign tick_lim = (UPD_BASE / 16) * ofcc_rate_mul(bw_q) - 1;

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			tick_cnt_q <= 32'h00000000;
			upd_tick_q <= 1'b0;
		end else if (tick_cnt_q >= tick_lim) begin
			tick_cnt_q <= 32'h00000000;
			upd_tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h00000001;
			upd_tick_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// sample fifo and low-pass filter
	// ----------------------------------------
	wire [DW-1:0] fifo_data;
	wire          fifo_valid;
	wire          fifo_in_ready;

	ofcc_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH), .AW(4)) u_fifo (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.in_data   (sample_data),
		.in_valid  (sample_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (upd_tick_q)
	);

	always @(posedge clk_sys or posedge reset) begin
		if (reset)
			sample_ready <= 1'b0;
		else
			sample_ready <= fifo_in_ready;
	end

	// the fifo drains one sample per update tick, so a fast front end sees back-pressure
	reg  [DW+7:0] acc_q;
	wire [DW-1:0] filt_val;
	wire [DW+7:0] acc_in;
	assign filt_val = acc_q[DW+7:8];
	assign acc_in   = {fifo_data, 8'h00};

	always @(posedge clk_sys or posedge reset) begin
		if (reset)
			acc_q <= {(DW+8){1'b0}};
		else if (upd_tick_q && fifo_valid) begin
			if (acc_in >= acc_q)
				acc_q <= acc_q + ((acc_in - acc_q) >> ofcc_shift(bw_q));
			else
				acc_q <= acc_q - ((acc_q - acc_in) >> ofcc_shift(bw_q));
		end
	end

	// ----------------------------------------
	// clamp
	// ----------------------------------------
	localparam [DW-1:0] HALF = {1'b1, {(DW-1){1'b0}}};
	reg  [DW-1:0] hi_lim;
	reg  [DW-1:0] lo_lim;
	reg  [5:0]    up_code;
	reg  [5:0]    lo_code;
	reg  [DW+5:0] span;

	always @* begin
		up_code = upper_set_q ? upper_q : FACTORY_UPPER;
		lo_code = lower_set_q ? lower_q : FACTORY_LOWER;
		// each code step removes 1/64 of the half range
		span    = {6'h00, HALF - 1'b1} * {{DW{1'b0}}, up_code};
		hi_lim  = ({1'b0, {(DW-1){1'b1}}} | HALF) - span[DW+5:6];
		span    = {6'h00, HALF} * {{DW{1'b0}}, lo_code};
		lo_lim  = span[DW+5:6];
	end

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			clamp_out   <= HALF;
			clamp_state <= 2'h0;
		end else if (upd_tick_q) begin
			if (filt_val > hi_lim) begin
				clamp_out   <= hi_lim;
				clamp_state <= 2'h2;
			end else if (filt_val < lo_lim) begin
				clamp_out   <= lo_lim;
				clamp_state <= 2'h1;
			end else begin
				clamp_out   <= filt_val;
				clamp_state <= 2'h0;
			end
		end
	end

	// ----------------------------------------
	// startup calibration and pwm encoder
	// ----------------------------------------
	localparam ST_CAL = 2'b01;
	localparam ST_RUN = 2'b10;
	reg [1:0]    state_q;
	reg [31:0]   cal_cnt_q;
	reg [DW-1:0] pwm_cnt_q;
	reg [DW-1:0] duty_q;

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_q    <= ST_CAL;
			cal_cnt_q  <= 32'h00000000;
			cal_active <= 1'b0;
		end else begin
			case (state_q)
			ST_CAL: begin
				// the window always runs its length; the enable may be loaded after reset and only gates the 50% duty
				if (cal_cnt_q >= CAL_CYCLES - 1) begin
					state_q    <= ST_RUN;
					cal_active <= 1'b0;
				end else begin
					cal_cnt_q  <= cal_cnt_q + 32'h00000001;
					cal_active <= cal_en_q;
				end
			end
			ST_RUN:  cal_active <= 1'b0;
			default: state_q <= ST_CAL;
			endcase
		end
	end

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pwm_cnt_q <= {DW{1'b0}};
			duty_q    <= HALF;
			pwm_out   <= 1'b0;
		end else begin
			pwm_cnt_q <= pwm_cnt_q + 1'b1;
			// duty only changes at a period boundary to avoid runt pulses
			if (pwm_cnt_q == {DW{1'b1}})
				duty_q <= cal_active ? HALF : clamp_out;
			pwm_out <= (pwm_cnt_q < duty_q);
		end
	end
endmodule

//--- ofcc_defs.vh
// constants for the output filter, clamp and calibration block
`ifndef OFCC_DEFS_VH
`define OFCC_DEFS_VH
// ----------------------------------------
// configuration word addresses and fields
// ----------------------------------------
`define OFCC_ADDR_FILTCLAMP   5'h1c
`define OFCC_ADDR_CALIB       5'h1e
`define OFCC_BW_LSB           0
`define OFCC_BW_MSB           2
`define OFCC_LOW_LSB          12
`define OFCC_LOW_MSB          17
`define OFCC_HIGH_LSB         18
`define OFCC_HIGH_MSB         23
`define OFCC_CAL_BIT          3
`define OFCC_RST_BW           3'h0
`define OFCC_RST_LIMIT        6'h00
`define OFCC_RST_CAL          1'b0
// ----------------------------------------
// timing
// ----------------------------------------
`define OFCC_CLK_HZ           100000000
`define OFCC_CAL_MS           800
`define OFCC_CAL_CYCLES       ((`OFCC_CLK_HZ / 1000) * `OFCC_CAL_MS)
`define OFCC_UPD_1K_CYCLES    (`OFCC_CLK_HZ / 1000)
`define OFCC_PWM_PERIOD       12'h3ff
`endif

//--- ofcc_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module ofcc_fifo #(
	parameter WIDTH = 10,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// clock and reset
	input  wire             clk_sys,
	input  wire             reset,
	// write side
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	// read side
	output reg  [WIDTH-1:0] out_data,
	output reg              out_valid,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_q;
	reg [AW:0]      rd_q;
	wire            full;
	wire            empty;
	wire            do_wr;
	wire            do_rd;

	assign full     = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
	assign empty    = (wr_q == rd_q);
	assign in_ready = ~full;
	assign do_wr    = in_valid & ~full;
	// output register refills whenever it is empty or being taken
	assign do_rd    = ~empty & (~out_valid | out_ready);

	always @(posedge clk_sys) begin
		if (do_wr)
			mem[wr_q[AW-1:0]] <= in_data;
	end

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wr_q      <= {(AW+1){1'b0}};
			rd_q      <= {(AW+1){1'b0}};
			out_data  <= {WIDTH{1'b0}};
			out_valid <= 1'b0;
		end else begin
			if (do_wr)
				wr_q <= wr_q + 1'b1;
			if (do_rd) begin
				out_data  <= mem[rd_q[AW-1:0]];
				rd_q      <= rd_q + 1'b1;
				out_valid <= 1'b1;
			end else if (out_ready)
				out_valid <= 1'b0;
		end
	end
endmodule

//--- ofcc_chk.sv
// concurrent checks on the back end ports
`timescale 1ns/1ps
module ofcc_chk #(
	parameter DW         = 10,
	parameter CAL_CYCLES = 3000,
	parameter UPD_BASE   = 800
) (
	// clock and reset
	input wire          clk_sys,
	input wire          reset,
	// configuration
	input wire          cfg_wr,
	input wire [4:0]    cfg_addr,
	input wire [23:0]   cfg_wdata,
	input wire [4:0]    cfg_raddr,
	input wire [23:0]   cfg_rdata,
	// output
	input wire [DW-1:0] clamp_out,
	input wire [1:0]    clamp_state,
	input wire          cal_active
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// ------------
	// shadow state
	// ------------
	reg [14:0]   fld_q;
	reg [31:0]   calc_q;
	reg [31:0]   gap_q;
	reg [DW-1:0] out_q;
	// a config write presets the gap count to 0x3e8, since the first tick after it may come early
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			fld_q <= 15'h0;
			calc_q <= 32'h0;
			gap_q <= 32'h3e8;
			out_q <= 10'h200;
		end else begin
			if (cfg_wr && cfg_addr == 5'h1c)
				fld_q <= {cfg_wdata[23:12], cfg_wdata[2:0]};
			calc_q <= cal_active ? calc_q + 32'h1 : 32'h0;
			gap_q <= cfg_wr ? 32'h3e8 : (clamp_out != out_q) ? 32'h0 : gap_q + 32'h1;
			out_q <= clamp_out;
		end
	end
	chk_unmapped_zero: assert property (!($past(cfg_raddr) inside {5'h1c, 5'h1e}) |-> cfg_rdata == 24'h0)
		else $error("unmapped read not zero");
	chk_field_read: assert property ($past(cfg_raddr) == 5'h1c |-> {cfg_rdata[23:12], cfg_rdata[2:0]} == $past(fld_q))
		else $error("field read back wrong");
	chk_upper_state: assert property (clamp_state == 2'h2 |-> clamp_out >= 10'h208)
		else $error("upper clamp below range");
	chk_lower_state: assert property (clamp_state == 2'h1 |-> clamp_out <= 10'h1f8)
		else $error("lower clamp above range");
	chk_state_code: assert property (clamp_state != 2'h3)
		else $error("bad clamp state");
	chk_cal_length: assert property (calc_q <= CAL_CYCLES)
		else $error("calibration window too long");
	chk_tick_gap: assert property (clamp_out != out_q |-> gap_q >= UPD_BASE / 16 - 1)
		else $error("update ticks too close");
	chk_cal_stop: assert property (cfg_wr && cfg_addr == 5'h1e && !cfg_wdata[3] |-> ##[1:2] !cal_active)
		else $error("calibration not stopped");
	cover property (clamp_state == 2'h2);
	cover property (clamp_state == 2'h1);
	cover property ($fell(cal_active));
endmodule
bind ofcc_top ofcc_chk #(.DW(DW), .CAL_CYCLES(CAL_CYCLES), .UPD_BASE(UPD_BASE)) ofcc_chk_inst (
	.clk_sys(clk_sys), .reset(reset), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
	.cfg_raddr(cfg_raddr), .cfg_rdata(cfg_rdata), .clamp_out(clamp_out), .clamp_state(clamp_state),
	.cal_active(cal_active));

//--- ofcc_ctl_model.sv
// controller model measuring pwm high time per carrier period
`timescale 1ns/1ps
module ofcc_ctl_model (
	// clock and reset
	input wire       clk_sys,
	input wire       reset,
	// pwm line and result
	input wire       pwm_in,
	output reg [9:0] duty_q,
	output reg       meas_ev
);
	reg [9:0]  pos_q;
	reg [10:0] hi_q;
	// -------------------------------------------
	// window of one period, phase free of the pwm
	// -------------------------------------------
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pos_q <= 10'h0;
			hi_q <= 11'h0;
			duty_q <= 10'h0;
			meas_ev <= 1'b0;
		end else begin
			pos_q <= pos_q + 10'h1;
			meas_ev <= &pos_q;
			hi_q <= (&pos_q) ? 11'h0 : hi_q + pwm_in;
			if (&pos_q)
				duty_q <= hi_q[9:0] + pwm_in;
		end
	end
endmodule

//--- output_filter_clamp_config_tb_top.sv
// bench for the output back end
`timescale 1ns/1ps
module output_filter_clamp_config_tb_top;
	reg        clk_sys = 0, reset = 1, cfg_wr = 0, sample_valid = 1;
	reg [4:0]  cfg_addr = 0, cfg_raddr = 0;
	reg [5:0]  c;
	reg [23:0] cfg_wdata = 0, e;
	reg [9:0]  sample_data = 10'h3ff, lim, prev = 10'h200;
	reg [31:0] rng = 32'hd04c, m, q[$];
	wire [23:0] cfg_rdata;
	wire [9:0] clamp_out, duty;
	wire [1:0] clamp_state;
	wire       sample_ready, pwm_out, cal_active, meas_ev;
	integer    n_fail = 0, cmp_count = 0, cyc = 0, gap = 0, last_gap = 0, i;
	event      probe;
	ofcc_top #(.CAL_CYCLES(3000), .UPD_BASE(800), .FACTORY_UPPER(6'h20)) ofcc_top_inst (.clk_sys(clk_sys), .reset(reset),
		.cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_raddr(cfg_raddr), .cfg_rdata(cfg_rdata),
		.sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready), .pwm_out(pwm_out),
		.clamp_out(clamp_out), .clamp_state(clamp_state), .cal_active(cal_active));
	ofcc_ctl_model ofcc_ctl_model_inst (.clk_sys(clk_sys), .reset(reset), .pwm_in(pwm_out), .duty_q(duty),
		.meas_ev(meas_ev));
	// -----
	// tasks
	// -----
	function [31:0] rnd;
		begin
			rng = rng ^ (rng << 13);
			rng = rng ^ (rng >> 17);
			rng = rng ^ (rng << 5);
			rnd = rng;
		end
	endfunction
	task tick(input integer n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task want(input [2:0] k, input [23:0] x);
		q.push_back({5'h0, k, x});
		->probe;
	endtask
	task wr(input [4:0] a, input [23:0] d);
		cfg_wr = 1;
		cfg_addr = a;
		cfg_wdata = d;
		tick(1);
		cfg_wr = 0;
	endtask
	task rd(input [4:0] a, input [23:0] x);
		cfg_raddr = a;
		tick(2);
		want(0, x);
	endtask
	task cmp_reg(input [23:0] x, input [23:0] y);
		cmp_count++;
		if (x !== y) begin
			n_fail++;
			$display("Error at %0t: expected %h got %h", $time, x, y);
		end
	endtask
	task cmp_out(input [23:0] x, input [10:0] y);
		cmp_reg(x, {13'h0, y});
	endtask
	task complete_run;
		$display("checks %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// -----------------
	// clock and monitor
	// -----------------
	initial forever #5 clk_sys = ~clk_sys;
	always @(probe) begin
		while (q.size() > 0) begin
			m = q.pop_front();
			case (m[26:24])
			3'h0: cmp_reg(m[23:0], cfg_rdata);
			3'h1: cmp_out(m[23:0], clamp_out);
			3'h2: cmp_out(m[23:0], clamp_state);
			3'h3: cmp_out(m[23:0], last_gap[10:0]);
			3'h4: cmp_out(m[23:0], duty);
			3'h5: cmp_out(m[23:0], sample_ready);
			default: cmp_out(m[23:0], cal_active);
			endcase
		end
	end
	// gap between output changes is the update period
	always @(posedge clk_sys) begin
		#2;
		cyc++;
		gap++;
		if (clamp_out != prev) begin
			last_gap = gap;
			gap = 0;
		end
		prev = clamp_out;
		if (cyc == 95000) begin
			n_fail++;
			complete_run;
		end
	end
	// ---------
	// scenarios
	// ---------
	initial begin
		tick(20);
		reset = 0;
		wr(5'h1e, 24'h8);
		repeat (2) @(posedge meas_ev);
		tick(1);
		want(4, 512);
		tick(1200);
		want(6, 0);
		want(1, 10'h300);
		want(2, 2);
		repeat (2) @(posedge meas_ev);
		tick(1);
		want(4, 10'h300);
		for (i = 0; i < 8; i++) begin
			c = (i % 4 == 3) ? 6'h3f : 6'h1 + rnd() % 63;
			sample_data = (i < 4) ? 10'h3ff : 10'h0;
			e = (i < 4) ? {c, 15'h0, 3'h1} : {6'h0, c, 9'h0, 3'h1};
			lim = (i < 4) ? 10'h3ff - c * 511 / 64 : c * 8;
			wr(5'h1c, e);
			tick(2500);
			want(1, lim);
			want(2, (i < 4) ? 2 : 1);
			rd(5'h1c, e);
		end
		for (i = 0; i < 8; i++) begin
			sample_data = i[0] ? 10'h0 : 10'h3ff;
			wr(5'h1c, i[23:0]);
			repeat (3) @(clamp_out);
			tick(1);
			want(3, (i == 1) ? 50 : (i == 3) ? 200 : (i == 4) ? 400 : (i == 5) ? 800 : 100);
		end
		wr(5'h1c, 24'h5);
		tick(40);
		want(5, 0);
		sample_valid = 0;
		wr(5'h1c, 24'h1);
		tick(1500);
		want(5, 1);
		for (i = 0; i < 3; i++) begin
			c = rnd() % 28;
			wr(c[4:0], rnd());
			rd(c[4:0], 0);
		end
		reset = 1;
		tick(20);
		reset = 0;
		wr(5'h1e, 24'h8);
		tick(50);
		want(6, 1);
		wr(5'h1e, 24'h0);
		tick(2);
		want(6, 0);
		complete_run;
	end
endmodule
